// ===== hdl/ics_core.sv
// busy sequencing of global commands and direct-sync data ready pacing
// assumes a register port on CORE_CLK and a sync pin driven from the link clock domain
//
// Functional notes
// - bit 7 of the global command register starts a reset and data stays invalid 255 ms.
// - bit 1 restores factory calibration and data stays invalid about 136 ms.
// - bit 3 saves the configuration to flash and data stays invalid about 70 ms.
// - bit 4 runs a flash test that ends within about 30 ms.
// - bit 2 runs a self test lasting about 24 ms.
// - with an external sample clock below 2000 Hz the self test stretches with it.
// - after power-up data stays invalid for about 310 ms.
// - data ready follows each sync edge by 305 us idle, up to 405 us under full traffic.
// - the extra delay grows in proportion to the words read, full at 64 words.
`timescale 1ns/1ps
`default_nettype none
`include "ics_defs.svh"
module ics_core
  import ics_pkg::*;
#(
  parameter int unsigned PWRUP_CYC = `ICS_MS_CYC(`ICS_T_PWRUP_MS),
  parameter int unsigned SRST_CYC = `ICS_MS_CYC(`ICS_T_SRST_MS),
  parameter int unsigned FCAL_CYC = `ICS_MS_CYC(`ICS_T_FCAL_MS),
  parameter int unsigned BKUP_CYC = `ICS_MS_CYC(`ICS_T_BKUP_MS),
  parameter int unsigned FTST_CYC = `ICS_MS_CYC(`ICS_T_FTST_MS),
  parameter int unsigned STST_CYC = `ICS_MS_CYC(`ICS_T_STST_MS),
  parameter int unsigned STDR_CYC = `ICS_US_CYC(`ICS_T_STDR_IDLE_US),
  parameter int unsigned FULL_WORDS = `ICS_FULL_WORDS,
  parameter int unsigned SAMPLE_PERIOD_CYC = 1000000 * `ICS_CLK_MHZ / `ICS_SAMPLE_HZ
) (
  // core clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_B,
  // link clock and sync pin
  input wire logic SYNC_CLK,
  input wire logic SYNC_IN,
  // register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [15:0] REG_RDATA,
  // serial word strobe, one pulse per 16-bit word read by the host
  input wire logic WORD_RD,
  // status
  output logic BUSY,
  output logic DATA_VALID,
  output logic DATA_READY
);
  localparam int unsigned EXTRA_CYC =
    `ICS_US_CYC(`ICS_T_STDR_FULL_US - `ICS_T_STDR_IDLE_US);
  localparam int unsigned STEP_CYC = EXTRA_CYC / FULL_WORDS;

  ics_req_t req;
  assign req = '{addr: REG_ADDR, wdata: REG_WDATA, wr: REG_WR, rd: REG_RD};

  // sync pin: first stage in the link domain, then a toggle per rising edge
  logic sync_l1_reg, sync_l2_reg, sync_l3_reg, sync_tog_reg;
  always_ff @(posedge SYNC_CLK) begin
    if (!RST_B) begin
      sync_l1_reg <= 1'b0;
      sync_l2_reg <= 1'b0;
      sync_l3_reg <= 1'b0;
      sync_tog_reg <= 1'b0;
    end else begin
      sync_l1_reg <= SYNC_IN;
      sync_l2_reg <= sync_l1_reg;
      sync_l3_reg <= sync_l2_reg;
      if (sync_l2_reg && !sync_l3_reg) begin
        sync_tog_reg <= ~sync_tog_reg;
      end
    end
  end

  // toggle into core domain
  logic tog_m_reg, tog_s_reg, tog_d_reg, sync_evt;
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      tog_m_reg <= 1'b0;
      tog_s_reg <= 1'b0;
      tog_d_reg <= 1'b0;
    end else begin
      tog_m_reg <= sync_tog_reg;
      tog_s_reg <= tog_m_reg;
      tog_d_reg <= tog_s_reg;
    end
  end
  assign sync_evt = tog_s_reg ^ tog_d_reg;

  // misc control register
  logic [15:0] misc_reg;
  logic direct_mode;
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      misc_reg <= `ICS_MISC_RST;
    end else if (req.wr && req.addr == `ICS_MISC_ADDR) begin
      misc_reg <= req.wdata;
    end
  end
  assign direct_mode = misc_reg[`ICS_SYNC_LSB +: 2] == `ICS_SYNC_DIRECT;

  // measured sync period, used to stretch the self test
  logic [31:0] per_cnt_reg, per_reg;
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      per_cnt_reg <= 32'h0;
      per_reg <= 32'h0;
    end else if (sync_evt) begin
      per_reg <= per_cnt_reg;
      per_cnt_reg <= 32'h0;
    end else if (per_cnt_reg != 32'hFFFFFFFF) begin
      per_cnt_reg <= per_cnt_reg + 32'h1;
    end
  end

  // self test length: nominal, scaled up when paced slower than the nominal rate
  logic [63:0] stst_scaled;
  logic [31:0] stst_len;
  always_comb begin
    stst_scaled = 64'(STST_CYC) * 64'(per_reg) / 64'(SAMPLE_PERIOD_CYC);
    stst_len = STST_CYC;
    if (direct_mode && per_reg > SAMPLE_PERIOD_CYC) begin
      stst_len = (stst_scaled > 64'hFFFFFFFF) ? 32'hFFFFFFFF : stst_scaled[31:0];
    end
  end

  // busy sequencer; core reset (RST_B) acts as power-up and external reset
  ics_state_t state_reg;
  logic [31:0] busy_cnt_reg;
  logic [15:0] glob_last_reg;
  logic cmd_wr;
  assign cmd_wr = req.wr && req.addr == `ICS_GLOB_ADDR;
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      state_reg <= ICS_BUSY;
      busy_cnt_reg <= PWRUP_CYC;
      glob_last_reg <= 16'h0000;
    end else begin
      unique case (state_reg)
        ICS_IDLE: begin
          // the busy pin lags the state by a cycle; gating on it also refuses the cycle after busy ends,
          // but the pin is still low in the cycle after acceptance, when the busy state already drops writes
          if (cmd_wr && !BUSY) begin
            glob_last_reg <= req.wdata;
            // priority: reset, then restore, backup, flash test, self test
            if (req.wdata[`ICS_BIT_SRST]) begin
              state_reg <= ICS_BUSY;
              busy_cnt_reg <= SRST_CYC;
            end else if (req.wdata[`ICS_BIT_FCAL]) begin
              state_reg <= ICS_BUSY;
              busy_cnt_reg <= FCAL_CYC;
            end else if (req.wdata[`ICS_BIT_BKUP]) begin
              state_reg <= ICS_BUSY;
              busy_cnt_reg <= BKUP_CYC;
            end else if (req.wdata[`ICS_BIT_FTST]) begin
              state_reg <= ICS_BUSY;
              busy_cnt_reg <= FTST_CYC;
            end else if (req.wdata[`ICS_BIT_STST]) begin
              state_reg <= ICS_BUSY;
              busy_cnt_reg <= stst_len;
            end
          end
        end
        ICS_BUSY: begin
          // commands written now are dropped
          if (busy_cnt_reg <= 32'h1) begin
            state_reg <= ICS_IDLE;
            busy_cnt_reg <= 32'h0;
          end else begin
            busy_cnt_reg <= busy_cnt_reg - 32'h1;
          end
        end
        default: begin
          state_reg <= ICS_IDLE;
          busy_cnt_reg <= 32'h0;
        end
      endcase
    end
  end

  // words read since last sync: each adds a share of the full-traffic extra delay
  logic [7:0] words_reg;
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      words_reg <= 8'h00;
    end else if (sync_evt) begin
      words_reg <= 8'h00;
    end else if (WORD_RD && words_reg < 8'(FULL_WORDS)) begin
      words_reg <= words_reg + 8'h01;
    end
  end

  // sync to data ready delay; a new sync restarts the wait
  logic pend_reg;
  logic [31:0] dr_cnt_reg;
  logic dr_due;
  assign dr_due = pend_reg && dr_cnt_reg >= STDR_CYC + 32'(words_reg) * STEP_CYC;
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      pend_reg <= 1'b0;
      dr_cnt_reg <= 32'h0;
    end else if (sync_evt && direct_mode) begin
      pend_reg <= 1'b1;
      dr_cnt_reg <= 32'h1;
    end else if (dr_due || state_reg != ICS_IDLE) begin
      pend_reg <= 1'b0;
      dr_cnt_reg <= 32'h0;
    end else if (pend_reg) begin
      dr_cnt_reg <= dr_cnt_reg + 32'h1;
    end
  end

  // outputs
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      DATA_READY <= 1'b0;
      BUSY <= 1'b1;
      DATA_VALID <= 1'b0;
    end else begin
      DATA_READY <= dr_due && state_reg == ICS_IDLE;
      BUSY <= state_reg != ICS_IDLE;
      DATA_VALID <= state_reg == ICS_IDLE;
    end
  end

  // register reads, data one cycle after the strobe
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      REG_RDATA <= 16'h0000;
    end else if (req.rd) begin
      unique case (req.addr)
        `ICS_GLOB_ADDR: REG_RDATA <= glob_last_reg;
        `ICS_MISC_ADDR: REG_RDATA <= misc_reg;
        `ICS_STAT_ADDR: REG_RDATA <= {13'h0, pend_reg, direct_mode, state_reg != ICS_IDLE};
        `ICS_TRAF_ADDR: REG_RDATA <= {8'h00, words_reg};
        default: REG_RDATA <= 16'h0000;
      endcase
    end else begin
      REG_RDATA <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/ics_defs.svh
// constants of the command/sync timing block
// assumes a 100 MHz core clock; long counts are also top-level parameters
`ifndef ICS_DEFS_SVH
`define ICS_DEFS_SVH
`define ICS_CLK_MHZ 100
`define ICS_GLOB_ADDR 8'h00
`define ICS_MISC_ADDR 8'h04
`define ICS_STAT_ADDR 8'h08
`define ICS_TRAF_ADDR 8'h0C
`define ICS_BIT_SRST 7
`define ICS_BIT_FCAL 1
`define ICS_BIT_BKUP 3
`define ICS_BIT_FTST 4
`define ICS_BIT_STST 2
`define ICS_SYNC_LSB 2
`define ICS_SYNC_DIRECT 2'h1
`define ICS_MISC_RST 16'h0000
`define ICS_T_PWRUP_MS 310
`define ICS_T_SRST_MS 255
`define ICS_T_FCAL_MS 136
`define ICS_T_BKUP_MS 70
`define ICS_T_FTST_MS 30
`define ICS_T_STST_MS 24
`define ICS_T_STDR_IDLE_US 305
`define ICS_T_STDR_FULL_US 405
`define ICS_FULL_WORDS 64
`define ICS_SAMPLE_HZ 2000
`define ICS_MS_CYC(ms) ((ms) * 1000 * `ICS_CLK_MHZ)
`define ICS_US_CYC(us) ((us) * `ICS_CLK_MHZ)
`endif

// ===== hdl/ics_pkg.sv
// types of the command/sync timing block
package ics_pkg;
  typedef enum logic [2:0] {
    ICS_IDLE = 3'b001,
    ICS_BUSY = 3'b010,
    ICS_WAIT = 3'b100
  } ics_state_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } ics_req_t;
endpackage

// ===== verif/ics_core_props.sv
// checker of busy lengths and data ready timing at the ics_core ports
// assumes a bind with the same shortened timing parameters
`timescale 1ns/1ps
`default_nettype none
`include "ics_defs.svh"
module ics_core_props #(
  parameter int unsigned PWRUP_CYC = 1, SRST_CYC = 2, FCAL_CYC = 3,
  parameter int unsigned BKUP_CYC = 4, FTST_CYC = 5, STST_CYC = 6, STDR_CYC = 7
) (
  // clock, reset and register writes
  input wire logic CORE_CLK, RST_B, REG_WR,
  input wire logic [7:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  // sync side and status
  input wire logic WORD_RD, SYNC_IN, BUSY, DATA_VALID, DATA_READY
);
  localparam int STEP = 156;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  int bc, len, sc, wc;
  logic sp, cmd_d;
  // busy shows one cycle after acceptance, so a write in that cycle is refused too
  wire logic cmd = REG_WR && REG_ADDR == `ICS_GLOB_ADDR && !BUSY && !cmd_d
    && |{REG_WDATA[7], REG_WDATA[4:1]};
  always_ff @(posedge CORE_CLK) begin
    sp <= SYNC_IN;
    cmd_d <= RST_B && cmd;
    bc <= (!RST_B || !BUSY) ? 0 : bc + 1;
    if (!RST_B)
      len <= PWRUP_CYC;
    else if (cmd)
      len <= REG_WDATA[7] ? SRST_CYC : REG_WDATA[1] ? FCAL_CYC : REG_WDATA[3] ? BKUP_CYC
        : REG_WDATA[4] ? FTST_CYC : STST_CYC;
  end
  // delay is measured from the raw pin, so the crossing latency sits in the margin
  always_ff @(posedge CORE_CLK) begin
    sc <= (SYNC_IN && !sp) ? 0 : sc + 1;
    wc <= (SYNC_IN && !sp) ? 0 : wc + int'(WORD_RD && wc < 64);
  end
  a_valid_not_busy: assert property (DATA_VALID == !BUSY)
    else $error("data valid disagrees with busy");
  a_cmd_goes_busy: assert property (cmd |-> ##2 BUSY)
    else $error("accepted command did not raise busy");
  a_busy_min_len: assert property ($fell(BUSY) |-> bc + 1 >= len)
    else $error("busy ended too early");
  a_ftst_bound: assert property ($fell(BUSY) && len == FTST_CYC |-> bc <= len + 2)
    else $error("flash test ran too long");
  a_ready_idle: assert property (DATA_READY |-> !BUSY)
    else $error("data ready while busy");
  a_ready_pulse: assert property (DATA_READY |=> !DATA_READY)
    else $error("data ready longer than one cycle");
  a_ready_not_early: assert property (DATA_READY |-> sc >= STDR_CYC + wc * STEP)
    else $error("data ready too early");
  a_ready_not_late: assert property (DATA_READY |-> sc <= STDR_CYC + wc * STEP + 30)
    else $error("data ready too late");
endmodule
`default_nettype wire

// ===== verif/ics_host_model.sv
// host side sync source: one sync pulse per rising edge of fire
// assumes fire is held for at least one link clock
`timescale 1ns/1ps
`default_nettype none
module ics_host_model #(
  parameter int HIGH_CYC = 160
) (
  input wire logic SYNC_CLK,
  input wire logic fire,
  output logic sync_o
);
  int n = 0;
  logic f1 = 1'b0;
  always @(posedge SYNC_CLK) begin
    f1 <= fire;
    if (fire && !f1)
      n <= HIGH_CYC; // above 5 us high at a 32 ns link clock
    else if (n > 0)
      n <= n - 1;
  end
  assign sync_o = n > 0;
endmodule
`default_nettype wire

// ===== verif/test_imu_command_sync_timing.sv
// bench of the command/sync timing block with shortened busy times
// assumes the checker and host model are compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "ics_defs.svh"
module test_imu_command_sync_timing;
  localparam int PW = 300, SR = 250, FC = 136, BK = 70, FT = 30, ST = 24, SD = 50;
  localparam int SP = 5000, GAP = 50100;
  localparam int BITS[5] = '{`ICS_BIT_SRST, `ICS_BIT_FCAL, `ICS_BIT_BKUP, `ICS_BIT_FTST,
    `ICS_BIT_STST};
  localparam int LENS[5] = '{SR, FC, BK, FT, ST};
  logic clk = 1'b0, sclk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, wrd = 1'b0, fire = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wd = 16'h0000;
  logic [31:0] rs = 32'h1818;
  logic [15:0] lc = 16'h0000;
  time t_last = 0, t_per = 0;
  wire logic [15:0] rdata;
  wire logic busy, valid, ready, sync;
  int err_count = 0, checks = 0;
  ics_core #(.PWRUP_CYC(PW), .SRST_CYC(SR), .FCAL_CYC(FC), .BKUP_CYC(BK), .FTST_CYC(FT),
    .STST_CYC(ST), .STDR_CYC(SD), .SAMPLE_PERIOD_CYC(SP)) u_dut (.CORE_CLK(clk),
    .RST_B(rst_b), .SYNC_CLK(sclk),
    .SYNC_IN(sync), .REG_ADDR(addr), .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd),
    .REG_RDATA(rdata), .WORD_RD(wrd), .BUSY(busy), .DATA_VALID(valid), .DATA_READY(ready));
  ics_host_model u_host (.SYNC_CLK(sclk), .fire(fire), .sync_o(sync));
  initial forever #5 clk = ~clk;
  initial begin
    #3;
    forever #16 sclk = ~sclk;
  end
  function automatic logic [31:0] nx(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // sync to data ready: idle figure plus a per-word share of the full-traffic extra
  function automatic int dr_exp(input int nw);
    return SD + nw * (`ICS_US_CYC(`ICS_T_STDR_FULL_US - `ICS_T_STDR_IDLE_US) / `ICS_FULL_WORDS);
  endfunction
  // self test stretches with the sync period once pacing is slower than nominal
  function automatic int st_exp(input int per);
    return (per > SP) ? ST * per / SP : ST;
  endfunction
  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic wrr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata === e, "read data");
  endtask
  // counts busy cycles from now; a restart by an ignored command shows as too long
  task automatic busy_len(input int n);
    int c;
    c = 0;
    while (busy === 1'b1 && c < 3000) begin
      @(posedge clk);
      #1 c++;
    end
    chk(c >= n - 2 && c <= n + 3 && valid === 1'b1, "busy length");
  endtask
  task automatic sync_dr(input int nw);
    int c;
    c = 0;
    fire <= 1'b1;
    while (sync !== 1'b1 && c < 50) begin
      @(posedge clk);
      #1 c++;
    end
    fire <= 1'b0;
    t_per = $time - t_last;
    t_last = $time;
    c = 0;
    while (ready !== 1'b1 && c < 2000) begin
      @(posedge clk);
      wrd <= (c == 30 && nw > 0); // one word at c == 30 when nw is nonzero adds one step to the gap
      #1 c++;
    end
    chk(c >= dr_exp(nw) && c <= dr_exp(nw) + 30, "data ready delay");
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    busy_len(PW);
    rdr(`ICS_MISC_ADDR, `ICS_MISC_RST);
    for (int i = 0; i < 5; i++) begin
      rs = nx(rs);
      lc = (rs[15:0] & 16'hFF61) | (16'h0001 << BITS[i]);
      wrr(`ICS_GLOB_ADDR, lc);
      wrr(`ICS_GLOB_ADDR, 16'h0080);
      busy_len(LENS[i] - 1);
      rs = nx(rs);
      rdr(rs[7:0] | 8'h10, 16'h0000);
    end
    rdr(`ICS_GLOB_ADDR, lc);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (1000) @(posedge clk);
    rst_b <= 1'b1;
    busy_len(PW);
    wrr(`ICS_MISC_ADDR, 16'h0004);
    rdr(`ICS_STAT_ADDR, 16'h0002);
    sync_dr(0);
    repeat (GAP) @(posedge clk);
    sync_dr(1);
    rdr(`ICS_TRAF_ADDR, 16'h0001);
    wrr(`ICS_GLOB_ADDR, 16'h0004);
    wrr(`ICS_GLOB_ADDR, 16'h0080);
    busy_len(st_exp(int'(t_per / 10)) - 1);
    tally_and_finish();
  end
endmodule
bind ics_core ics_core_props #(.PWRUP_CYC(PWRUP_CYC), .SRST_CYC(SRST_CYC),
  .FCAL_CYC(FCAL_CYC), .BKUP_CYC(BKUP_CYC), .FTST_CYC(FTST_CYC), .STST_CYC(STST_CYC),
  .STDR_CYC(STDR_CYC)) u_props (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .REG_WR(REG_WR),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .WORD_RD(WORD_RD), .SYNC_IN(SYNC_IN),
  .BUSY(BUSY), .DATA_VALID(DATA_VALID), .DATA_READY(DATA_READY));
`default_nettype wire
